/* clfm_pkg.sv */
package clfm_pkg;
   // =====================================
   // Timing
   // =====================================
   localparam int unsigned CLK_PERIOD_PS        = 5000;
   localparam int unsigned TX_DOM_TIMEOUT_US    = 1000;
   localparam int unsigned BUS_DOM_TIMEOUT_US   = 1000;
   localparam int unsigned TX_DOM_TIMEOUT_CYC   = (TX_DOM_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
   localparam int unsigned BUS_DOM_TIMEOUT_CYC  = (BUS_DOM_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
   localparam int unsigned CNT_W                = 24;
   localparam int unsigned FAULT_CNT            = 5;

   // =====================================
   // Fault bit positions
   // =====================================
   localparam int unsigned F_TXDOM  = 0;
   localparam int unsigned F_RXREC  = 1;
   localparam int unsigned F_SHORT  = 2;
   localparam int unsigned F_BUSDOM = 3;
   localparam int unsigned F_THERM  = 4;

   typedef enum logic [1:0] {
      CLFM_NORMAL,
      CLFM_LISTEN,
      CLFM_STANDBY,
      CLFM_SLEEP
   } clfm_mode_e;
endpackage : clfm_pkg

/* clfm_timer.sv */
`timescale 1ns/100ps
`default_nettype none
// =====================================
// Run-length timer, fires when level held past limit
// =====================================
module clfm_timer #(
   parameter int unsigned W     = clfm_pkg::CNT_W,
   parameter int unsigned LIMIT = clfm_pkg::TX_DOM_TIMEOUT_CYC
) (
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   input  wire logic active_i,
   output var  logic expired_o
);
   logic [W-1:0] cnt_reg;
   wire          at_limit = (cnt_reg >= W'(LIMIT));

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg   <= '0;
         expired_o <= 1'b0;
      end else if (!active_i) begin
         cnt_reg   <= '0;
         expired_o <= 1'b0;
      end else begin
         if (!at_limit) cnt_reg <= cnt_reg + 1'b1;
         expired_o <= at_limit;
      end
   end
endmodule : clfm_timer
`default_nettype wire

/* clfm_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Five local faults; any one sets the single local failure flag.
// - Every fault but bus clamp disables transmitter; all but over-temperature only until flag clears.
// - Transmit input low past its time-out sets flag, disables transmitter.
// - Bus dominant but receive output recessive sets flag, disables transmitter.
// - Transmit-to-receive short sets flag and disables transmitter.
// - Bus dominant past its time-out sets the flag.
// - Bus clamp keeps transmitter on; indication clears when bus recessive.
// - Over-temperature disables transmitter until cooled by hysteresis and flag clear.
// - Receive dominant while transmit recessive clears flag, re-enables transmitter.
// - In listen-only mode error output goes high once flag clears.
// - Entering normal mode from any other mode clears the flag.
// - Entering listen-only from normal shows flag as low error output.
module clfm_monitor #(
   parameter int unsigned TX_DOM_CYC  = clfm_pkg::TX_DOM_TIMEOUT_CYC,
   parameter int unsigned BUS_DOM_CYC = clfm_pkg::BUS_DOM_TIMEOUT_CYC
) (
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       txd_i,
   input  wire logic       rxd_i,
   input  wire logic       bus_dominant_i,
   input  wire logic       thermal_trip_level_i,
   input  wire logic       thermal_trip_hysteresis_i,
   input  wire logic       tx_rx_short_i,
   input  wire logic [1:0] mode_i,
   output var  logic       tx_drive_dominant_o,
   output var  logic       tx_enabled_o,
   output var  logic       local_fail_o,
   output var  logic       err_n_o,
   output var  logic [4:0] fault_src_o
);
   // =====================================
   // Mode decode
   // =====================================
   logic [1:0] mode_reg;
   wire        is_normal   = (mode_i == 2'(clfm_pkg::CLFM_NORMAL));
   wire        is_listen   = (mode_i == 2'(clfm_pkg::CLFM_LISTEN));
   wire        was_normal  = (mode_reg == 2'(clfm_pkg::CLFM_NORMAL));
   wire        enter_norm  = is_normal && !was_normal;
   wire        enter_list  = is_listen && was_normal;

   // =====================================
   // Fault detectors
   // =====================================
   logic       tx_timeout;
   logic       bus_timeout;
   logic       thermal_hold_reg;
   logic       lf_reg;
   logic       tx_dis_reg;
   logic       lf_show_reg;

   clfm_timer #(.W(clfm_pkg::CNT_W), .LIMIT(TX_DOM_CYC)) u_tx_timer (
      .mclk_i    (mclk_i),
      .rst_n_i   (rst_n_i),
      .active_i  (!txd_i),
      .expired_o (tx_timeout)
   );

   clfm_timer #(.W(clfm_pkg::CNT_W), .LIMIT(BUS_DOM_CYC)) u_bus_timer (
      .mclk_i    (mclk_i),
      .rst_n_i   (rst_n_i),
      .active_i  (bus_dominant_i),
      .expired_o (bus_timeout)
   );

   wire rx_stuck   = bus_dominant_i && rxd_i && !tx_dis_reg;
   wire tx_short   = tx_rx_short_i;
   wire thermal    = thermal_trip_level_i;
   wire [4:0] fault_vec = {thermal, bus_timeout, tx_short, rx_stuck, tx_timeout};
   wire any_fault  = |fault_vec;
   wire dis_fault  = tx_timeout | rx_stuck | tx_short | thermal;
   wire bus_clear  = lf_reg && !tx_dis_reg && !bus_dominant_i;
   wire recov_cond = !rxd_i && txd_i && !(dis_fault | bus_timeout);
   wire clr        = recov_cond | enter_norm | bus_clear;
   wire cool_ok    = !thermal_hold_reg || thermal_trip_hysteresis_i;

   // =====================================
   // Flag and transmitter state
   // =====================================
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_reg <= 2'(clfm_pkg::CLFM_STANDBY);
      end else begin
         mode_reg <= mode_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lf_reg      <= 1'b0;
         tx_dis_reg  <= 1'b0;
         fault_src_o <= '0;
      end else if (any_fault) begin
         lf_reg      <= 1'b1;
         tx_dis_reg  <= tx_dis_reg | dis_fault;
         fault_src_o <= fault_src_o | fault_vec;
      end else if (clr) begin
         lf_reg      <= 1'b0;
         tx_dis_reg  <= tx_dis_reg && !cool_ok;
         fault_src_o <= '0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         thermal_hold_reg <= 1'b0;
      end else if (thermal) begin
         thermal_hold_reg <= 1'b1;
      end else if (thermal_trip_hysteresis_i) begin
         thermal_hold_reg <= 1'b0;
      end
   end

   // =====================================
   // Error indication
   // =====================================
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lf_show_reg <= 1'b0;
      end else if (enter_list) begin
         lf_show_reg <= 1'b1;
      end else if (!is_listen) begin
         lf_show_reg <= 1'b0;
      end
   end

   wire show_fail = is_listen && (lf_show_reg || enter_list);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         err_n_o             <= 1'b1;
         tx_drive_dominant_o <= 1'b0;
         tx_enabled_o        <= 1'b1;
         local_fail_o        <= 1'b0;
      end else begin
         err_n_o             <= !(show_fail && lf_reg);
         tx_drive_dominant_o <= !txd_i && !tx_dis_reg && !dis_fault;
         tx_enabled_o        <= !tx_dis_reg;
         local_fail_o        <= lf_reg;
      end
   end
endmodule : clfm_monitor
`default_nettype wire

/* clfm_monitor_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ==================================
// Local fault flag checks
module clfm_monitor_chk (
   input wire logic       mclk_i,
   input wire logic       rst_n_i,
   input wire logic       txd_i,
   input wire logic       rxd_i,
   input wire logic       bus_dominant_i,
   input wire logic       thermal_trip_level_i,
   input wire logic       tx_rx_short_i,
   input wire logic [1:0] mode_i,
   input wire logic       tx_drive_dominant_o,
   input wire logic       tx_enabled_o,
   input wire logic       local_fail_o,
   input wire logic       err_n_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   wire quiet = txd_i && !tx_rx_short_i && !thermal_trip_level_i && !bus_dominant_i;
   property p_short; tx_rx_short_i |-> ##[1:3] (local_fail_o && !tx_enabled_o); endproperty
   a_short: assert property (p_short) else $error("short not flagged");
   property p_therm; thermal_trip_level_i |-> ##[1:3] (local_fail_o && !tx_enabled_o); endproperty
   a_therm: assert property (p_therm) else $error("heat not flagged");
   property p_rxrec; bus_dominant_i && rxd_i && tx_enabled_o |-> ##[1:3] local_fail_o; endproperty
   a_rxrec: assert property (p_rxrec) else $error("stuck receive not flagged");
   property p_drive; !tx_enabled_o |-> !tx_drive_dominant_o; endproperty
   a_drive: assert property (p_drive) else $error("disabled driver dominant");
   property p_clear; (!rxd_i && quiet)[*2] |-> ##[1:2] !local_fail_o; endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");
   property p_normal; $past(mode_i) != 2'h0 && mode_i == 2'h0 && quiet |-> ##[1:3] !local_fail_o; endproperty
   a_normal: assert property (p_normal) else $error("normal entry kept flag");
   property p_listen; $past(mode_i) == 2'h0 && mode_i == 2'h1 && local_fail_o |-> ##[1:2] !err_n_o; endproperty
   a_listen: assert property (p_listen) else $error("flag not shown");
   property p_err; mode_i == 2'h1 && $fell(local_fail_o) |-> ##[0:1] err_n_o; endproperty
   a_err: assert property (p_err) else $error("error output stayed low");
   c_off: cover property ($fell(tx_enabled_o));
   c_on: cover property ($rose(tx_enabled_o));
   c_shown: cover property ($fell(err_n_o));
endmodule : clfm_monitor_chk
bind clfm_monitor clfm_monitor_chk u_chk (.*);
`default_nettype wire

/* clfm_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module clfm_ctrl_model (
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       frame_i,
   input  wire logic       stuck_i,
   input  wire logic [1:0] mode_req_i,
   output var  logic       txd_o,
   output var  logic [1:0] mode_o
);
   logic [1:0] bit_cnt_reg;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {bit_cnt_reg, txd_o, mode_o} <= 5'h04;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 2'h1;
         txd_o       <= !(stuck_i || (frame_i && bit_cnt_reg[1]));
         mode_o      <= mode_req_i;
      end
   end
endmodule : clfm_ctrl_model
`default_nettype wire

/* test_can_local_fault_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module test_can_local_fault_monitor;
   logic       mclk_i = 1'b0, rst_n_i = 1'b0, rxd_i = 1'b1, bus_dominant_i = 1'b0;
   logic       thermal_trip_level_i = 1'b0, thermal_trip_hysteresis_i = 1'b0;
   logic       tx_rx_short_i = 1'b0, frame = 1'b0, stuck = 1'b0;
   logic [1:0] mode_req = 2'h0, mode_i;
   logic       txd_i, tx_drive_dominant_o, tx_enabled_o, local_fail_o, err_n_o;
   logic [4:0] fault_src_o;
   int         fail_count = 0, n_compared = 0;
   wire  [2:0] st = {local_fail_o, tx_enabled_o, tx_drive_dominant_o};
   wire  [2:0] se = {local_fail_o, tx_enabled_o, err_n_o};
   always #2.5 mclk_i = ~mclk_i;
   clfm_ctrl_model u_ctrl (.mclk_i, .rst_n_i, .frame_i(frame), .stuck_i(stuck),
                           .mode_req_i(mode_req), .txd_o(txd_i), .mode_o(mode_i));
   clfm_monitor #(.TX_DOM_CYC(20), .BUS_DOM_CYC(20)) u_dut (.*);
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask : cyc
   task automatic chk(input int sel, input logic [4:0] e);
      logic [4:0] g;
      @(negedge mclk_i);
      g = (sel == 2) ? fault_src_o : {2'h0, (sel == 1) ? se : st};
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
      end
      @(posedge mclk_i);
   endtask : chk
   task automatic clr;
      rxd_i <= 1'b0; cyc(3); rxd_i <= 1'b1; cyc(3);
   endtask : clr
   task automatic t_frame;
      frame <= 1'b1; cyc(40); frame <= 1'b0; cyc(3); chk(0, 5'h02);
   endtask : t_frame
   task automatic t_clamp;
      bus_dominant_i <= 1'b1; rxd_i <= 1'b0; cyc(28); chk(0, 5'h06);
      bus_dominant_i <= 1'b0; rxd_i <= 1'b1; cyc(4); chk(0, 5'h02);
   endtask : t_clamp
   task automatic t_stuck;
      stuck <= 1'b1; cyc(5); chk(0, 5'h03);
      cyc(22); chk(0, 5'h04);
      stuck <= 1'b0; cyc(2); clr; chk(0, 5'h02);
   endtask : t_stuck
   task automatic t_therm;
      thermal_trip_level_i <= 1'b1; cyc(2); thermal_trip_level_i <= 1'b0; cyc(3);
      chk(0, 5'h04);
      chk(2, 5'h10);
      clr; chk(0, 5'h00);
      thermal_trip_hysteresis_i <= 1'b1; cyc(2); thermal_trip_hysteresis_i <= 1'b0;
      clr; chk(0, 5'h02);
   endtask : t_therm
   task automatic t_listen;
      tx_rx_short_i <= 1'b1; cyc(2); tx_rx_short_i <= 1'b0; cyc(3); chk(0, 5'h04);
      mode_req <= 2'h1; cyc(4); chk(1, 5'h04);
      clr; chk(1, 5'h03);
      mode_req <= 2'h0; cyc(4);
   endtask : t_listen
   task automatic t_mode;
      bus_dominant_i <= 1'b1; cyc(3); bus_dominant_i <= 1'b0; cyc(2); chk(0, 5'h04);
      chk(2, 5'h02);
      mode_req <= 2'h2; cyc(3); mode_req <= 2'h0; cyc(4); chk(0, 5'h02);
   endtask : t_mode
   task automatic give_verdict;
      $display("compared %0d, failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      cyc(8); rst_n_i <= 1'b1; cyc(2);
      t_frame; t_clamp; t_stuck; t_therm; t_listen; t_mode;
      give_verdict;
   end
   initial begin
      #20000;
      fail_count++;
      give_verdict;
   end
endmodule : test_can_local_fault_monitor
`default_nettype wire
